// ### logic/mcra_pkg.sv
package mcra_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TERM_BAUD       = 2400;
  localparam int unsigned FRAME_BITS      = 10;
  localparam int unsigned BYTE_CYCLES     = CLK_HZ / TERM_BAUD * FRAME_BITS;

  localparam logic [7:0]  CH_CR           = 8'h0d;
  localparam logic [7:0]  CH_A            = 8'h41;
  localparam logic [7:0]  CH_T            = 8'h54;
  localparam logic [7:0]  CH_H            = 8'h48;
  localparam logic [7:0]  CH_I            = 8'h49;
  localparam logic [7:0]  CH_M            = 8'h4d;
  localparam logic [7:0]  CH_O            = 8'h4f;
  localparam logic [7:0]  CH_R            = 8'h52;
  localparam logic [7:0]  CH_S            = 8'h53;
  localparam logic [7:0]  CH_Z            = 8'h5a;
  localparam logic [7:0]  CH_W_LO         = 8'h77;
  localparam logic [7:0]  CH_R_LO         = 8'h72;
  localparam logic [7:0]  CH_M_LO         = 8'h6d;
  localparam logic [7:0]  CH_Q_LO         = 8'h71;
  localparam logic [7:0]  CH_Z_LO         = 8'h7a;
  localparam logic [7:0]  CH_EQ           = 8'h3d;
  localparam logic [7:0]  CH_QM           = 8'h3f;
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam logic [7:0]  OFFSET_PREFIX   = 8'h55;

  localparam logic [1:0]  SPK_OFF         = 2'h0;
  localparam logic [1:0]  SPK_UNTIL_CARR  = 2'h1;
  localparam logic [1:0]  SPK_ALWAYS      = 2'h2;
  localparam logic [1:0]  SPK_AFTER_DIAL  = 2'h3;

  localparam logic [7:0]  REG_MON_LEVEL   = 8'hf4;
  localparam logic [3:0]  MON_LEVEL_MAX   = 4'hf;
  localparam logic [7:0]  REG_WAKE        = 8'h62;
  localparam int unsigned WAKE_ALERT_BIT  = 4;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;

  localparam logic [7:0]  KEEP_E0         = 8'he0;
  localparam logic [7:0]  KEEP_E2         = 8'he2;
  localparam logic [7:0]  KEEP_E4         = 8'he4;
  localparam logic [7:0]  KEEP_E7         = 8'he7;
  localparam logic [7:0]  KEEP_F8         = 8'hf8;
  localparam logic [7:0]  KEEP_F9         = 8'hf9;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h00,
    ST_GOT_A = 5'h01,
    ST_CMD   = 5'h02,
    ST_M_DIG = 5'h03,
    ST_R_O   = 5'h04,
    ST_S_A1  = 5'h05,
    ST_S_A2  = 5'h06,
    ST_S_OP  = 5'h07,
    ST_S_V1  = 5'h08,
    ST_S_V2  = 5'h09,
    ST_S_CR  = 5'h0a,
    ST_W_A   = 5'h0b,
    ST_W_V   = 5'h0c,
    ST_R_A   = 5'h0d,
    ST_M_A   = 5'h0e,
    ST_Q_A   = 5'h0f,
    ST_MON   = 5'h10,
    ST_SLEEP = 5'h11
  } mcra_state_e;

  function automatic logic mcra_sw_keep(input logic [7:0] a);
    mcra_sw_keep = (a == KEEP_E0) || (a == KEEP_E2) || (a == KEEP_F8) ||
                   (a == KEEP_F9) || ((a >= KEEP_E4) && (a <= KEEP_E7));
  endfunction

endpackage

// ### logic/mcra_hex_codec.sv
`timescale 1ns/100ps
module mcra_hex_codec (
  input  wire logic [7:0] i_ascii,
  input  wire logic [7:0] i_byte,
  output logic      [3:0] o_nib,
  output logic            o_is_hex,
  output logic      [7:0] o_hi_char,
  output logic      [7:0] o_lo_char
);

  function automatic logic [7:0] to_char(input logic [3:0] n);
    to_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Upper-case digits only: the parser is case-sensitive
  always_comb begin
    o_nib    = 4'h0;
    o_is_hex = 1'b0;
    if (i_ascii >= 8'h30 && i_ascii <= 8'h39) begin
      o_nib    = i_ascii[3:0];
      o_is_hex = 1'b1;
    end else if (i_ascii >= 8'h41 && i_ascii <= 8'h46) begin
      o_nib    = i_ascii[3:0] + 4'h9;
      o_is_hex = 1'b1;
    end
  end

  assign o_hi_char = to_char(i_byte[7:4]);
  assign o_lo_char = to_char(i_byte[3:0]);

endmodule

// ### logic/mcra_pacer.sv
`timescale 1ns/100ps
module mcra_pacer #(
  parameter int unsigned PERIOD = 416_660
) (
  input  wire logic I_CLK_SYS,
  input  wire logic I_RST_N,
  input  wire logic i_run,
  output logic      o_tick
);

  localparam int unsigned CW = $clog2(PERIOD + 1);

  logic [CW-1:0] cnt_r;

  // Restarts from zero whenever idle, so the first repeat waits a full byte time
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_r <= '0;
    end else if (!i_run || o_tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_tick = i_run && (cnt_r == CW'(PERIOD - 1));

endmodule

// ### logic/mcra_top.sv
`timescale 1ns/100ps
module mcra_top
  import mcra_pkg::*;
#(
  parameter logic [3:0]  REVISION    = 4'h3, // Arbitrary revision number
  parameter int unsigned BYTE_CYCLES = mcra_pkg::BYTE_CYCLES
) (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST_N,
  input  wire logic       i_RX_VALID,
  input  wire logic [7:0] i_RX_DATA,
  output logic            o_RX_READY,
  output logic            o_TX_VALID,
  output logic      [7:0] o_TX_DATA,
  input  wire logic       i_TX_READY,
  input  wire logic [7:0] i_REG_ADDR,
  input  wire logic [7:0] i_REG_WDATA,
  input  wire logic       i_REG_WR,
  input  wire logic       i_REG_RD,
  output logic      [7:0] o_REG_RDATA,
  input  wire logic       i_CARRIER,
  input  wire logic       i_DIAL_DONE,
  input  wire logic       i_RING,
  output logic            o_HANGUP,
  output logic            o_ONLINE,
  output logic            o_TURNAROUND,
  output logic            o_SPEAKER_ON,
  output logic            o_LOW_POWER,
  output logic            o_ALERT
);

  typedef struct packed {
    mcra_state_e       st;
    logic [7:0]        addr;
    logic [3:0]        val_hi;
    logic [1:0][7:0]   txq;
    logic [1:0]        txn;
    logic [1:0]        spk;
    logic              hangup;
    logic              online;
    logic              turn;
    logic              low_pw;
    logic              alert;
    logic              carr_d;
    logic              carr_seen;
    logic              dialed;
    logic              ring_m;
    logic              ring_s;
    logic              ring_d;
    logic [7:0]        rdata;
    logic [255:0][7:0] regs;
  } mcra_state_s;

  localparam mcra_state_s RESET_STATE = '{
    st:        ST_IDLE,
    addr:      8'h00,
    val_hi:    4'h0,
    txq:       '0,
    txn:       2'h0,
    spk:       SPK_OFF,
    hangup:    1'b0,
    online:    1'b0,
    turn:      1'b0,
    low_pw:    1'b0,
    alert:     1'b0,
    carr_d:    1'b0,
    carr_seen: 1'b0,
    dialed:    1'b0,
    ring_m:    1'b0,
    ring_s:    1'b0,
    ring_d:    1'b0,
    rdata:     8'h00,
    regs:      {256{REG_RESET_VAL}}
  };

  mcra_state_s s_r;
  mcra_state_s s_nxt;

  logic       rx_take;
  logic [3:0] rx_nib;
  logic       rx_hex;
  logic [7:0] hi_char;
  logic [7:0] lo_char;
  logic [7:0] sel_byte;
  logic       mon_tick;

  assign o_RX_READY = (s_r.txn == 2'h0);
  assign rx_take    = i_RX_VALID && o_RX_READY;
  assign sel_byte   = s_r.regs[s_r.addr];

  mcra_hex_codec u_codec (
    .i_ascii   (i_RX_DATA),
    .i_byte    (sel_byte),
    .o_nib     (rx_nib),
    .o_is_hex  (rx_hex),
    .o_hi_char (hi_char),
    .o_lo_char (lo_char)
  );

  mcra_pacer #(
    .PERIOD (BYTE_CYCLES)
  ) u_pacer (
    .I_CLK_SYS (I_CLK_SYS),
    .I_RST_N   (I_RST_N),
    .i_run     (s_r.st == ST_MON),
    .o_tick    (mon_tick)
  );

  always_comb begin
    s_nxt        = s_r;
    s_nxt.hangup = 1'b0;
    s_nxt.turn   = 1'b0;
    s_nxt.ring_m = i_RING;
    s_nxt.ring_s = s_r.ring_m;
    s_nxt.ring_d = s_r.ring_s;
    s_nxt.carr_d = i_CARRIER;
    s_nxt.rdata  = i_REG_RD ? s_r.regs[i_REG_ADDR] : 8'h00;

    if (i_TX_READY && s_r.txn != 2'h0) begin
      s_nxt.txq[0] = s_r.txq[1];
      s_nxt.txn    = s_r.txn - 2'h1;
    end

    if (i_REG_WR) begin
      s_nxt.regs[i_REG_ADDR] = i_REG_WDATA;
    end

    if (i_DIAL_DONE) begin
      s_nxt.dialed = 1'b1;
    end

    // Connection established: carrier rising edge
    if (i_CARRIER && !s_r.carr_d) begin
      s_nxt.carr_seen = 1'b1;
      if (s_r.spk == SPK_UNTIL_CARR) begin
        s_nxt.regs[REG_MON_LEVEL][3:0] = MON_LEVEL_MAX;
      end
    end

    // Only the synchronised ring ends sleep; host bytes are dropped, carrier, dial and register writes still act
    if (s_r.st == ST_SLEEP) begin
      if (s_r.ring_s && !s_r.ring_d) begin
        s_nxt.low_pw = 1'b0;
        s_nxt.st     = ST_IDLE;
        s_nxt.txq[0] = CH_R;
        s_nxt.txn    = 2'h1;
        s_nxt.alert  = s_r.regs[REG_WAKE][WAKE_ALERT_BIT];
      end
    end else if (rx_take) begin
      s_nxt.alert = 1'b0;
      unique case (s_r.st)
        ST_IDLE: begin
          if (i_RX_DATA == CH_A) begin
            s_nxt.st = ST_GOT_A;
          end
        end
        ST_GOT_A: begin
          if (i_RX_DATA == CH_T) begin
            s_nxt.st = ST_CMD;
          end else if (i_RX_DATA != CH_A) begin
            s_nxt.st = ST_IDLE;
          end
        end
        ST_CMD: begin
          unique case (i_RX_DATA)
            CH_CR: begin
              s_nxt.st = ST_IDLE;
            end
            CH_H: begin
              s_nxt.hangup    = 1'b1;
              s_nxt.online    = 1'b0;
              s_nxt.carr_seen = 1'b0;
              s_nxt.dialed    = 1'b0;
            end
            CH_I: begin
              s_nxt.txq[0] = CH_ZERO + {4'h0, REVISION};
              s_nxt.txn    = 2'h1;
            end
            CH_M: begin
              s_nxt.st = ST_M_DIG;
            end
            CH_O: begin
              s_nxt.online = 1'b1;
            end
            CH_R: begin
              s_nxt.st = ST_R_O;
            end
            CH_S: begin
              s_nxt.st = ST_S_A1;
            end
            CH_W_LO: begin
              s_nxt.st = ST_W_A;
            end
            CH_R_LO: begin
              s_nxt.st = ST_R_A;
            end
            CH_M_LO: begin
              s_nxt.st = ST_M_A;
            end
            CH_Q_LO: begin
              s_nxt.st = ST_Q_A;
            end
            CH_Z: begin
              for (int i = 0; i < 256; i++) begin
                if (!mcra_sw_keep(8'(i))) begin
                  s_nxt.regs[i] = REG_RESET_VAL;
                end
              end
              s_nxt.spk       = SPK_OFF;
              s_nxt.online    = 1'b0;
              s_nxt.carr_seen = 1'b0;
              s_nxt.dialed    = 1'b0;
              s_nxt.st        = ST_IDLE;
            end
            CH_Z_LO: begin
              s_nxt.low_pw = 1'b1;
              s_nxt.st     = ST_SLEEP;
            end
            default: begin
            end
          endcase
        end
        ST_M_DIG: begin
          if (i_RX_DATA[7:2] == CH_ZERO[7:2]) begin
            s_nxt.spk = i_RX_DATA[1:0];
          end
          s_nxt.st = ST_CMD;
        end
        ST_R_O: begin
          if (i_RX_DATA == CH_O) begin
            s_nxt.turn   = 1'b1;
            s_nxt.online = 1'b1;
          end
          s_nxt.st = ST_CMD;
        end
        ST_S_A1: begin
          s_nxt.addr[7:4] = rx_nib;
          s_nxt.st        = rx_hex ? ST_S_A2 : ST_CMD;
        end
        ST_S_A2: begin
          s_nxt.addr[3:0] = rx_nib;
          s_nxt.st        = rx_hex ? ST_S_OP : ST_CMD;
        end
        ST_S_OP: begin
          if (i_RX_DATA == CH_EQ) begin
            s_nxt.st = ST_S_V1;
          end else if (i_RX_DATA == CH_QM) begin
            s_nxt.st = ST_S_CR;
          end else begin
            s_nxt.st = ST_CMD;
          end
        end
        ST_S_V1: begin
          s_nxt.val_hi = rx_nib;
          s_nxt.st     = rx_hex ? ST_S_V2 : ST_CMD;
        end
        ST_S_V2: begin
          if (rx_hex) begin
            s_nxt.regs[s_r.addr] = {s_r.val_hi, rx_nib};
          end
          s_nxt.st = ST_CMD;
        end
        ST_S_CR: begin
          // Answer waits for end of line; other bytes are ignored
          if (i_RX_DATA == CH_CR) begin
            s_nxt.txq[0] = hi_char;
            s_nxt.txq[1] = lo_char;
            s_nxt.txn    = 2'h2;
            s_nxt.st     = ST_IDLE;
          end
        end
        ST_W_A: begin
          s_nxt.addr = i_RX_DATA;
          s_nxt.st   = ST_W_V;
        end
        ST_W_V: begin
          s_nxt.regs[s_r.addr] = i_RX_DATA;
          s_nxt.st             = ST_CMD;
        end
        ST_R_A: begin
          s_nxt.addr   = i_RX_DATA;
          s_nxt.txq[0] = s_r.regs[i_RX_DATA];
          s_nxt.txn    = 2'h1;
          s_nxt.st     = ST_CMD;
        end
        ST_M_A: begin
          s_nxt.addr   = i_RX_DATA;
          s_nxt.txq[0] = s_r.regs[i_RX_DATA];
          s_nxt.txn    = 2'h1;
          s_nxt.st     = ST_MON;
        end
        ST_Q_A: begin
          s_nxt.addr   = i_RX_DATA;
          s_nxt.txq[0] = OFFSET_PREFIX;
          s_nxt.txq[1] = s_r.regs[i_RX_DATA];
          s_nxt.txn    = 2'h2;
          s_nxt.st     = ST_CMD;
        end
        ST_MON: begin
          // The stopping byte is consumed, not parsed as a command
          s_nxt.st = ST_CMD;
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end else if (s_r.st == ST_MON && mon_tick && s_r.txn == 2'h0) begin
      s_nxt.txq[0] = sel_byte;
      s_nxt.txn    = 2'h1;
    end
  end

  // Async reset restores every register, exempt ones included
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    unique case (s_r.spk)
      SPK_OFF:        o_SPEAKER_ON = 1'b0;
      SPK_UNTIL_CARR: o_SPEAKER_ON = !s_r.carr_seen;
      SPK_ALWAYS:     o_SPEAKER_ON = 1'b1;
      SPK_AFTER_DIAL: o_SPEAKER_ON = s_r.dialed && !s_r.carr_seen;
    endcase
  end

  assign o_TX_VALID   = (s_r.txn != 2'h0);
  assign o_TX_DATA    = s_r.txq[0];
  assign o_REG_RDATA  = s_r.rdata;
  assign o_HANGUP     = s_r.hangup;
  assign o_ONLINE     = s_r.online;
  assign o_TURNAROUND = s_r.turn;
  assign o_LOW_POWER  = s_r.low_pw;
  assign o_ALERT      = s_r.alert;

endmodule

// ### tb/mcra_top_props.sv
`timescale 1ns/100ps
module mcra_top_props
  import mcra_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST_N,
  input wire logic       i_RX_VALID,
  input wire logic       o_RX_READY,
  input wire logic       o_TX_VALID,
  input wire logic [7:0] o_TX_DATA,
  input wire logic       i_TX_READY,
  input wire logic       i_REG_RD,
  input wire logic [7:0] o_REG_RDATA,
  input wire logic       o_HANGUP,
  input wire logic       o_ONLINE,
  input wire logic       o_TURNAROUND,
  input wire logic       o_LOW_POWER,
  input wire logic       o_ALERT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  property p_tx_hold;
    o_TX_VALID && !i_TX_READY |=> o_TX_VALID && $stable(o_TX_DATA);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed before accept");
  property p_rd_idle;
    !i_REG_RD |=> o_REG_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_refuse;
    o_TX_VALID |-> !o_RX_READY;
  endproperty
  a_refuse: assert property (p_refuse) else $error("host byte taken while reply pending");
  property p_hangup;
    o_HANGUP |-> !o_ONLINE ##1 !o_HANGUP;
  endproperty
  a_hangup: assert property (p_hangup) else $error("hang-up left line online");
  property p_turn;
    o_TURNAROUND |-> ##[0:1] o_ONLINE;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround did not go online");
  property p_sleep_quiet;
    o_LOW_POWER |-> !o_TX_VALID;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("serial port active in sleep");
  property p_wake;
    $fell(o_LOW_POWER) |-> ##[0:2] (o_TX_VALID && o_TX_DATA == CH_R);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without ring report");
  property p_alert;
    o_ALERT && !(i_RX_VALID && o_RX_READY) |=> o_ALERT;
  endproperty
  a_alert: assert property (p_alert) else $error("alert dropped on its own");
  c_wake: cover property ($fell(o_LOW_POWER));
  c_turn: cover property (o_TURNAROUND);
  c_hangup: cover property (o_HANGUP);
endmodule

bind mcra_top mcra_top_props i_mcra_top_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_RX_VALID(i_RX_VALID),
  .o_RX_READY(o_RX_READY), .o_TX_VALID(o_TX_VALID), .o_TX_DATA(o_TX_DATA),
  .i_TX_READY(i_TX_READY), .i_REG_RD(i_REG_RD), .o_REG_RDATA(o_REG_RDATA),
  .o_HANGUP(o_HANGUP), .o_ONLINE(o_ONLINE), .o_TURNAROUND(o_TURNAROUND),
  .o_LOW_POWER(o_LOW_POWER), .o_ALERT(o_ALERT)
);

// ### tb/mcra_host_model.sv
`timescale 1ns/100ps
module mcra_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_got_stb,
  output logic      [7:0] o_got
);
  logic ph_r;
  // Slow mode accepts every other cycle, so replies must stand while stalled
  assign o_tx_ready = !i_slow || ph_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_r      <= 1'b0;
      o_got_stb <= 1'b0;
      o_got     <= 8'h00;
    end else begin
      ph_r      <= !ph_r;
      o_got_stb <= i_tx_valid && o_tx_ready;
      o_got     <= i_tx_data;
    end
  end
endmodule

// ### tb/mcra_top_tb.sv
`timescale 1ns/100ps
module mcra_top_tb;
  import mcra_pkg::*;
  localparam int unsigned BC = 20;
  localparam logic [3:0] REV = 4'h3; // Arbitrary revision number
  localparam logic [7:0] KEEP [6] = '{8'he0, 8'he2, 8'he4, 8'he7, 8'hf8, 8'hf9};
  localparam logic [7:0] WIPE [5] = '{8'he1, 8'he3, 8'he8, 8'hf7, 8'h34};
  logic       clk, rst_n, rx_v, rx_rdy, tx_v, tx_rdy, wr, rd, carr, dial, ring, slow;
  logic       hup, onl, turn, spk, lowp, alert, got_stb;
  logic [7:0] rx_d, tx_d, addr, wdata, rdata, got;
  logic [7:0] q [$];
  int         n_errors, tests_run, cyc;

  mcra_top #(.REVISION(REV), .BYTE_CYCLES(BC)) i_mcra_top (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .i_RX_VALID(rx_v), .i_RX_DATA(rx_d),
    .o_RX_READY(rx_rdy), .o_TX_VALID(tx_v), .o_TX_DATA(tx_d), .i_TX_READY(tx_rdy),
    .i_REG_ADDR(addr), .i_REG_WDATA(wdata), .i_REG_WR(wr), .i_REG_RD(rd),
    .o_REG_RDATA(rdata), .i_CARRIER(carr), .i_DIAL_DONE(dial), .i_RING(ring),
    .o_HANGUP(hup), .o_ONLINE(onl), .o_TURNAROUND(turn), .o_SPEAKER_ON(spk),
    .o_LOW_POWER(lowp), .o_ALERT(alert));
  mcra_host_model i_mcra_host_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_tx_valid(tx_v),
    .i_tx_data(tx_d), .o_tx_ready(tx_rdy), .o_got_stb(got_stb), .o_got(got));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (got_stb) q.push_back(got);
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task flag(input logic f, input logic e, input string what);
    chk({7'h0, f}, {7'h0, e}, what);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task snd(input logic [7:0] b);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_d <= b;
    do @(negedge clk); while (rx_rdy !== 1'b1);
    @(posedge clk);
    rx_v <= 1'b0;
    rx_d <= ~b;
  endtask
  task str(input string s);
    for (int i = 0; i < s.len(); i++) snd(s[i]);
  endtask
  task wr_r(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
  task rd_r(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, e, "register");
  endtask
  // Bounded wait; an absent byte is compared as unknown and so reported
  task exp_b(input logic [7:0] e);
    int k;
    k = 0;
    while (q.size() == 0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk((q.size() != 0) ? q.pop_front() : 8'hxx, e, "reply byte");
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {rst_n, rx_v, wr, rd, carr, dial, ring, slow} = 8'h00;
    {rx_d, addr, wdata} = 24'h000000;
    wt(20);
    rst_n <= 1'b1;
    rd_r(REG_WAKE, 8'h00);
    str("ATS14=80w");
    snd(8'h34);
    snd(8'h58);
    snd(CH_R_LO);
    snd(8'h34);
    exp_b(8'h58);
    rd_r(8'h34, 8'h58);
    wt(1);
    slow <= 1'b1;
    snd(CH_Q_LO);
    snd(8'h34);
    exp_b(OFFSET_PREFIX);
    exp_b(8'h58);
    slow <= 1'b0;
    $display("test binary done");
    str("ATS14=80S35=A2");
    rd_r(8'h35, 8'ha2);
    str("S34?");
    snd(CH_CR);
    exp_b("5");
    exp_b("8");
    rd_r(8'h14, 8'h80);
    str("ATI");
    snd(CH_CR);
    exp_b(CH_ZERO + {4'h0, REV});
    $display("test hex done");
    str("ATO");
    wt(3);
    flag(onl, 1'b1, "online");
    snd(CH_CR);
    str("ATH");
    @(negedge clk);
    flag(hup, 1'b1, "hangup");
    wt(3);
    flag(onl, 1'b0, "online");
    str("RO");
    @(negedge clk);
    flag(turn, 1'b1, "turnaround");
    wt(3);
    flag(onl, 1'b1, "online");
    snd(CH_CR);
    str("ATM2");
    wt(2);
    flag(spk, 1'b1, "speaker");
    str("M0");
    wt(2);
    flag(spk, 1'b0, "speaker");
    str("M3");
    wt(2);
    flag(spk, 1'b0, "speaker");
    dial <= 1'b1;
    wt(1);
    dial <= 1'b0;
    wt(2);
    flag(spk, 1'b1, "speaker");
    carr <= 1'b1;
    wt(3);
    flag(spk, 1'b0, "speaker");
    carr <= 1'b0;
    // Hang-up first: the carrier seen under option 3 would keep the speaker off
    str("HM1");
    wt(2);
    flag(spk, 1'b1, "speaker");
    carr <= 1'b1;
    wt(3);
    flag(spk, 1'b0, "speaker");
    rd_r(REG_MON_LEVEL, 8'h0f);
    snd(CH_CR);
    carr <= 1'b0;
    $display("test mode done");
    foreach (KEEP[i]) wr_r(KEEP[i], 8'h11);
    foreach (WIPE[i]) wr_r(WIPE[i], 8'h22);
    str("ATZ");
    wt(3);
    foreach (KEEP[i]) rd_r(KEEP[i], 8'h11);
    foreach (WIPE[i]) rd_r(WIPE[i], 8'h00);
    wr_r(8'h34, 8'h5a);
    str("ATS14=80m");
    snd(8'h34);
    repeat (3) exp_b(8'h5a);
    snd(8'h00);
    wt(5);
    q.delete();
    wt(3 * BC);
    chk(8'(q.size()), 8'h00, "monitor stop");
    snd(CH_CR);
    $display("test reset monitor done");
    wr_r(REG_WAKE, 8'h10);
    str("ATz");
    wt(2);
    flag(lowp, 1'b1, "sleep");
    snd(CH_A);
    wt(2);
    chk(8'(q.size()), 8'h00, "sleep reply");
    ring <= 1'b1;
    wt(4);
    ring <= 1'b0;
    exp_b(CH_R);
    flag(lowp, 1'b0, "sleep");
    flag(alert, 1'b1, "alert");
    @(posedge clk);
    rst_n <= 1'b0;
    wt(3);
    flag(alert, 1'b0, "alert");
    rst_n <= 1'b1;
    wt(2);
    rd_r(8'he0, 8'h00);
    rd_r(REG_WAKE, 8'h00);
    $display("test wake done");
    results();
  end
endmodule
